// file: logic/pmev_params.svh
// Constants of the event, flag and power-ok block: flag layout, masks, timing.
// Assumes a 125 MHz core clock; included by the package, pmev_short_det and pmev_top.
//
// Overview of operation
// RQ1: Current limit sets a maskable overcurrent flag; clear refused while limit persists.
// RQ2: Buck output low 1 ms disables that rail, sets unmaskable short flag.
// RQ3: Linear output low 1 ms disables that rail, sets unmaskable short flag.
// RQ4: Die warning sets maskable flag, live status; clear refused while still hot.
// RQ5: Thermal shutdown disables all rails, drops both outputs, unmaskable flag and status.
// RQ6: Supply overvoltage disables all rails, drops both outputs, unmaskable flag and status.
// RQ7: Each rail sets its good flag on valid or invalid, separate masks.
// RQ8: Power-ok falling to inactive sets a maskable flag with status bit.
// RQ9: Sync clock appearing or vanishing sets maskable flag and clock status.
// RQ10: Enabling clock detector without a clock raises the clock-change flag.
// RQ11: Finished current measurement sets a maskable flag without status bit.
// RQ12: Undervoltage lockout shuts down and restores defaults, no flag raised.
// RQ13: Leaving lockout loads one-time bits, starts and sets reset flag on the same edge.
// RQ14: Software reset shuts down, restores defaults, restarts, sets reset flag.
// RQ15: Power-ok status reads one when valid; polarity inverts only the pin.
// RQ16: Each rail joins power-ok by its own select bit, voltage only.
// RQ17: A disabled rail is ignored by power-ok monitoring.
// RQ18: A select bit adds live thermal warning as power-ok source.
// RQ19: Power-ok active only when selected sources, overvoltage, shutdown flags are clear.
// RQ20: Window bit zero checks undervoltage only, one checks both limits.
// RQ21: Configuration picks power-ok pin polarity and push-pull or open-drain drive.
// RQ22: A one-time bit picks gated or continuous power-ok mode; power_ok_mode is loaded but drives no logic.
// RQ23: Interrupt line low while any unmasked flag is pending.
// RQ24: Reset flag mask reloaded from one-time bits on every reset sequence.
// RQ25: Writing zero keeps flags; an event in the clearing cycle wins.
`ifndef PMEV_PARAMS_SVH
`define PMEV_PARAMS_SVH

`define PMEV_NRAIL        4
`define PMEV_NFLAG        19
`define PMEV_NSYNC        21
// Flag positions; rails 1:0 are bucks, 3:2 linear
`define PMEV_F_OC         0
`define PMEV_F_SC         4
`define PMEV_F_PG         8
`define PMEV_F_WARN       12
`define PMEV_F_SD         13
`define PMEV_F_OVP        14
`define PMEV_F_POKF       15
`define PMEV_F_CLK        16
`define PMEV_F_MEAS       17
`define PMEV_F_RST        18
`define PMEV_UNMASKABLE   19'h060f0
`define PMEV_FLAGS_RST    19'h00000
// Short-circuit debounce
`define PMEV_CLK_MHZ      125
`define PMEV_SHORT_US     1000
`define PMEV_SHORT_CW     17

`endif

// file: logic/pmev_pkg.sv
// Types shared by the event and power-ok block.
// Assumes pmev_params.svh on the include path.
`include "pmev_params.svh"
package pmev_pkg;
   // Reset sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_OFF  = 3'b001,
      ST_LOAD = 3'b010,
      ST_RUN  = 3'b100
   } pmev_state_t;
   typedef logic [`PMEV_NFLAG-1:0] pmev_flags_t;
   typedef logic [`PMEV_NRAIL-1:0] pmev_rail_t;
endpackage : pmev_pkg

// file: logic/pmev_sync3.sv
// Three-stage synchroniser with agreement filter for analog comparator pins.
// Assumes inputs asynchronous to core_clk.
`timescale 1ns/1ps
module pmev_sync3 #(
   parameter int W = 1
) (
   input  wire logic         core_clk, // Core clock
   input  wire logic         rstn,     // Synchronous reset, low
   input  wire logic         ce,       // Clock enable
   input  wire logic [W-1:0] d,        // Raw inputs
   output logic      [W-1:0] q         // Filtered inputs
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   // Stage chain; a bit moves once stages two and three agree
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q    <= '0;
      end else if (ce) begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q    <= (s2_r & s3_r) | (q & (s2_r ^ s3_r));
      end
   end
endmodule : pmev_sync3

// file: logic/pmev_short_det.sv
// Per-rail short/overload debounce: trips after the output sits low for CYC cycles.
// Assumes low is synchronised and en is the rail's live enable.
`timescale 1ns/1ps
`include "pmev_params.svh"
module pmev_short_det #(
   parameter int unsigned CYC = `PMEV_SHORT_US * `PMEV_CLK_MHZ
) (
   input  wire logic core_clk, // Core clock
   input  wire logic rstn,     // Synchronous reset, low
   input  wire logic ce,       // Clock enable
   input  wire logic en,       // Rail enabled
   input  wire logic low,      // Output below short level
   output logic      trip      // Trip, held while low persists at the count limit
);
   localparam logic [`PMEV_SHORT_CW-1:0] LAST = `PMEV_SHORT_CW'(CYC - 1);
   logic [`PMEV_SHORT_CW-1:0] cnt_r;

   // Counts from enable or from the first low sample
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         cnt_r <= '0;
      end else if (ce) begin
         if (!en || !low) begin
            cnt_r <= '0;
         end else if (cnt_r != LAST) begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end

   // Same test covers start-up and running overload
   assign trip = ce & en & low & (cnt_r == LAST); // [RQ2] [RQ3]
endmodule : pmev_short_det

// file: logic/pmev_top.sv
// Event flags, interrupt line, rail protection and power-ok output logic.
// Assumes analog comparator levels arrive on raw pins; controls and clears come
// from register logic on core_clk. Rails 1:0 are bucks, 3:2 linear regulators.
`timescale 1ns/1ps
`include "pmev_params.svh"
module pmev_top #(
   parameter int unsigned SHORT_CYC = `PMEV_SHORT_US * `PMEV_CLK_MHZ
) (
   input  wire logic                 core_clk,           // 125 MHz clock
   input  wire logic                 rstn,               // Synchronous reset, low
   input  wire logic                 ce,                 // Clock enable
   input  wire logic                 supply_undervolt_lockout, // Raw lockout pin
   input  wire logic                 sw_reset_req,       // Software reset pulse
   input  wire logic                 otp_reset_mask,     // One-time reset flag mask
   input  wire logic                 otp_power_ok_mode,  // One-time mode, 1 continuous
   input  wire logic                 reset_mask_wr,      // Write strobe, reset mask
   input  wire logic                 reset_mask_wdata,   // Reset mask write data
   input  wire pmev_pkg::pmev_rail_t rail_en_req,        // Requested rail enables
   input  wire logic                 out_a_req,          // Requested output a
   input  wire logic                 out_b_req,          // Requested output b
   input  wire pmev_pkg::pmev_rail_t ilim_raw,           // Raw current limit
   input  wire pmev_pkg::pmev_rail_t short_low_raw,      // Raw below short level
   input  wire pmev_pkg::pmev_rail_t above_uv_raw,       // Raw above undervoltage
   input  wire pmev_pkg::pmev_rail_t below_ov_raw,       // Raw below overvoltage
   input  wire logic                 hot_warning_raw,    // Raw die warning
   input  wire logic                 hot_shutdown_raw,   // Raw die shutdown
   input  wire logic                 supply_overvolt_raw, // Raw supply overvoltage
   input  wire logic                 sync_clk_present_raw, // Raw clock detect
   input  wire logic                 clk_det_en,         // Clock detector enable
   input  wire logic                 measure_done,       // Measurement done pulse
   input  wire pmev_pkg::pmev_flags_t flag_clr,          // Write-one-to-clear
   input  wire pmev_pkg::pmev_flags_t event_mask,        // Per-flag masks
   input  wire pmev_pkg::pmev_rail_t good_rise_mask,     // Rail valid masks
   input  wire pmev_pkg::pmev_rail_t good_fall_mask,     // Rail invalid masks
   input  wire pmev_pkg::pmev_rail_t monitor_select,     // Rails feeding power-ok
   input  wire logic                 hot_warning_monitor_select, // Warning to power-ok
   input  wire pmev_pkg::pmev_rail_t rail_check_window,  // 1 checks both limits
   input  wire logic                 power_ok_polarity,  // 1 inverts pin
   input  wire logic                 power_ok_drain_type, // 1 open-drain
   output pmev_pkg::pmev_flags_t     flags,              // Flag register
   output pmev_pkg::pmev_rail_t      overcurrent_status, // Live limit status
   output pmev_pkg::pmev_rail_t      good_status,        // Live rail validity
   output logic                      hot_warning_status, // Live warning
   output logic                      hot_shutdown_status, // Live shutdown
   output logic                      supply_overvolt_status, // Live overvoltage
   output logic                      sync_clk_status,    // Live clock present
   output logic                      power_ok_status,    // 1 when valid
   output logic                      power_ok_mode,      // Loaded mode bit
   output logic                      reset_mask,         // Current reset mask
   output pmev_pkg::pmev_rail_t      rail_enable,        // Rail enables
   output logic                      general_output_a,   // Output a
   output logic                      general_output_b,   // Output b
   output logic                      power_ok_output_o,  // Pin drive level
   output logic                      power_ok_output_oe, // Pin drive enable
   output logic                      irq_line_low,       // Interrupt, low active
   output logic                      running             // Sequencer in run
);
   import pmev_pkg::*;

   pmev_state_t          state_r;
   pmev_state_t          state_nxt;
   logic [`PMEV_NSYNC-1:0] sync_q;
   pmev_rail_t           ilim_s;
   pmev_rail_t           low_s;
   pmev_rail_t           uv_s;
   pmev_rail_t           ov_s;
   logic                 warn_s;
   logic                 sd_s;
   logic                 ovp_s;
   logic                 clkp_s;
   logic                 lock_s;
   pmev_rail_t           good_c;
   pmev_rail_t           trip;
   pmev_rail_t           dis_r;
   pmev_rail_t           ilim_p_r;
   pmev_rail_t           good_p_r;
   logic                 clkp_p_r;
   logic                 det_p_r;
   pmev_flags_t          flags_nxt;
   pmev_flags_t          set_c;
   pmev_flags_t          hold_c;
   pmev_flags_t          mask_c;
   pmev_rail_t           rail_ok;
   logic                 pok_valid;
   logic                 force_off;
   logic                 run;
   logic                 pok_lvl;

   // Comparator pins into the core clock domain
   pmev_sync3 #(.W(`PMEV_NSYNC)) u_sync (
      .core_clk (core_clk),
      .rstn     (rstn),
      .ce       (ce),
      .d        ({supply_undervolt_lockout, sync_clk_present_raw, supply_overvolt_raw,
                  hot_shutdown_raw, hot_warning_raw, below_ov_raw, above_uv_raw,
                  short_low_raw, ilim_raw}),
      .q        (sync_q)
   );
   assign {lock_s, clkp_s, ovp_s, sd_s, warn_s, ov_s, uv_s, low_s, ilim_s} = sync_q;
   assign run = (state_r == ST_RUN);

   // Reset sequencer: off, load one-time bits, run
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_OFF:  if (!lock_s) state_nxt = ST_LOAD;                     // [RQ13]
         ST_LOAD: state_nxt = ST_RUN;
         ST_RUN:  if (lock_s || sw_reset_req) state_nxt = ST_OFF;       // [RQ12] [RQ14]
         default: state_nxt = ST_OFF;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state_r <= ST_OFF;
      end else if (ce) begin
         state_r <= state_nxt;
      end
   end

   // One-time bits reloaded on every pass through load
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         reset_mask    <= 1'b0;
         power_ok_mode <= 1'b0;
      end else if (ce) begin
         if (state_r == ST_LOAD) begin
            reset_mask    <= otp_reset_mask;     // [RQ24]
            power_ok_mode <= otp_power_ok_mode;  // [RQ22]
         end else if (run && reset_mask_wr) begin
            reset_mask    <= reset_mask_wdata;
         end
      end
   end

   // Per-rail validity, short debounce and disable latch
   genvar gi;
   generate
      for (gi = 0; gi < `PMEV_NRAIL; gi++) begin : g_rail
         assign good_c[gi]  = uv_s[gi] & (~rail_check_window[gi] | ov_s[gi]); // [RQ20]
         assign rail_ok[gi] = ~monitor_select[gi] | ~rail_enable[gi]      // [RQ16] [RQ17]
                              | good_c[gi];
         pmev_short_det #(.CYC(SHORT_CYC)) u_sc (
            .core_clk (core_clk),
            .rstn     (rstn),
            .ce       (ce),
            .en       (rail_enable[gi]),
            .low      (low_s[gi]),
            .trip     (trip[gi])
         );
         always_ff @(posedge core_clk) begin
            if (!rstn) begin
               dis_r[gi] <= 1'b0;
            end else if (ce) begin
               if (!run || !rail_en_req[gi]) begin
                  dis_r[gi] <= 1'b0;
               end else if (trip[gi]) begin
                  dis_r[gi] <= 1'b1;                       // [RQ2] [RQ3]
               end
            end
         end
      end
   endgenerate

   // Shutdown and overvoltage stay in force until their flags are cleared
   assign force_off = sd_s | ovp_s | flags[`PMEV_F_SD] | flags[`PMEV_F_OVP];

   // Rail enables and general outputs
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rail_enable      <= '0;
         general_output_a <= 1'b0;
         general_output_b <= 1'b0;
      end else if (ce) begin
         rail_enable      <= (run && !force_off) ? (rail_en_req & ~dis_r & ~trip) : '0; // [RQ5] [RQ6]
         general_output_a <= run & ~force_off & out_a_req;                  // [RQ5] [RQ6]
         general_output_b <= run & ~force_off & out_b_req;
      end
   end

   // Event set terms
   always_comb begin
      set_c                          = '0;
      set_c[`PMEV_F_OC +: 4]         = ilim_s & ~ilim_p_r;                          // [RQ1]
      set_c[`PMEV_F_SC +: 4]         = trip;                                        // [RQ2] [RQ3]
      set_c[`PMEV_F_PG +: 4]         = (good_c & ~good_p_r & ~good_rise_mask)       // [RQ7]
                                     | (~good_c & good_p_r & ~good_fall_mask);
      set_c[`PMEV_F_WARN]            = warn_s & ~hot_warning_status;                // [RQ4]
      set_c[`PMEV_F_SD]              = sd_s & ~hot_shutdown_status;                 // [RQ5]
      set_c[`PMEV_F_OVP]             = ovp_s & ~supply_overvolt_status;             // [RQ6]
      set_c[`PMEV_F_POKF]            = power_ok_status & ~pok_valid;                // [RQ8]
      set_c[`PMEV_F_CLK]             = clk_det_en & ((clkp_s ^ clkp_p_r)            // [RQ9]
                                     | (~det_p_r & ~clkp_s));                       // [RQ10]
      set_c[`PMEV_F_MEAS]            = measure_done;                                // [RQ11]
      set_c[`PMEV_F_RST]             = (state_r == ST_LOAD);                        // [RQ13] [RQ14]
      if (!run && state_r != ST_LOAD) begin
         set_c = '0;                                                                // [RQ12]
      end
   end

   // Conditions that refuse a clear while still present
   always_comb begin
      hold_c                  = '0;
      hold_c[`PMEV_F_OC +: 4] = ilim_s;   // [RQ1]
      hold_c[`PMEV_F_WARN]    = warn_s;   // [RQ4]
      hold_c[`PMEV_F_SD]      = sd_s;     // [RQ5]
      hold_c[`PMEV_F_OVP]     = ovp_s;    // [RQ6]
   end

   // Set wins over a clear; zero writes change nothing
   assign flags_nxt = set_c | (flags & ~(flag_clr & ~hold_c)); // [RQ25]

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         flags <= `PMEV_FLAGS_RST;
      end else if (ce) begin
         flags <= (state_r == ST_OFF) ? `PMEV_FLAGS_RST : flags_nxt; // [RQ12]
      end
   end

   // Live status bits and edge history
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         overcurrent_status     <= '0;
         good_status            <= '0;
         hot_warning_status     <= 1'b0;
         hot_shutdown_status    <= 1'b0;
         supply_overvolt_status <= 1'b0;
         sync_clk_status        <= 1'b0;
         ilim_p_r               <= '0;
         good_p_r               <= '0;
         clkp_p_r               <= 1'b0;
         det_p_r                <= 1'b0;
      end else if (ce) begin
         overcurrent_status     <= ilim_s;
         good_status            <= good_c;  // [RQ7]
         hot_warning_status     <= warn_s;  // [RQ4]
         hot_shutdown_status    <= sd_s;
         supply_overvolt_status <= ovp_s;
         sync_clk_status        <= clkp_s;  // [RQ9]
         ilim_p_r               <= ilim_s;
         good_p_r               <= good_c;
         clkp_p_r               <= clkp_s;
         det_p_r                <= clk_det_en;
      end
   end

   // Power-ok combine of selected sources
   assign pok_valid = (&rail_ok)                                              // [RQ19]
                    & ~(hot_warning_monitor_select & warn_s)                  // [RQ18]
                    & ~flags[`PMEV_F_OVP] & ~flags[`PMEV_F_SD];
   assign pok_lvl   = power_ok_status ^ power_ok_polarity;                    // [RQ15]

   // Status and pin drive; open-drain only sinks
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         power_ok_status    <= 1'b0;
         power_ok_output_o  <= 1'b0;
         power_ok_output_oe <= 1'b0;
      end else if (ce) begin
         power_ok_status    <= run & pok_valid;                               // [RQ15]
         power_ok_output_o  <= power_ok_drain_type ? 1'b0 : pok_lvl;          // [RQ21]
         power_ok_output_oe <= power_ok_drain_type ? ~pok_lvl : 1'b1;         // [RQ21]
      end
   end

   // Interrupt line: pending unmasked flags pull it low
   always_comb begin
      mask_c               = event_mask & ~`PMEV_UNMASKABLE;
      mask_c[`PMEV_F_PG +: 4] = 4'h0;
      mask_c[`PMEV_F_RST]  = reset_mask;
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         irq_line_low <= 1'b1;
      end else if (ce) begin
         irq_line_low <= ~|(flags & ~mask_c); // [RQ23]
      end
   end

   assign running = run;

   // Checks
   AST_IRQ_LOW: assert property (@(posedge core_clk) disable iff (!rstn) // [RQ23]
      ce && |(flags & ~mask_c) |=> !irq_line_low)
      else $error("irq line not low with pending flag");
   AST_IRQ_HIGH: assert property (@(posedge core_clk) disable iff (!rstn) // [RQ23]
      ce && !(|(flags & ~mask_c)) |=> irq_line_low)
      else $error("irq line low with nothing pending");
   AST_OC_HOLD: assert property (@(posedge core_clk) disable iff (!rstn) // [RQ1]
      ce && run && flags[`PMEV_F_OC] && ilim_s[0] && flag_clr[`PMEV_F_OC]
      |=> flags[`PMEV_F_OC])
      else $error("overcurrent flag cleared while limit active");
   AST_SHORT_OFF: assert property (@(posedge core_clk) disable iff (!rstn) // [RQ2]
      ce && trip[1] |=> !rail_enable[1] && flags[`PMEV_F_SC + 1])
      else $error("tripped rail still enabled");
   AST_SHORT_LIN: assert property (@(posedge core_clk) disable iff (!rstn) // [RQ3]
      ce && trip[2] |=> !rail_enable[2] && flags[`PMEV_F_SC + 2])
      else $error("tripped linear rail still enabled");
   AST_SD_OFF: assert property (@(posedge core_clk) disable iff (!rstn) // [RQ5]
      ce && sd_s |=> rail_enable == '0 && !general_output_a && !general_output_b)
      else $error("outputs alive in thermal shutdown");
   AST_OVP_OFF: assert property (@(posedge core_clk) disable iff (!rstn) // [RQ6]
      ce && ovp_s |=> rail_enable == '0 && !general_output_a && !general_output_b)
      else $error("outputs alive in overvoltage");
   AST_POK_PIN: assert property (@(posedge core_clk) disable iff (!rstn) // [RQ15]
      ce && !power_ok_drain_type |=>
      power_ok_output_o == ($past(power_ok_status) ^ $past(power_ok_polarity)))
      else $error("power-ok pin level wrong");
   AST_POK_FALL: assert property (@(posedge core_clk) disable iff (!rstn) // [RQ8]
      ce && run && power_ok_status && !pok_valid |=> flags[`PMEV_F_POKF] && !power_ok_status)
      else $error("power-ok fall not flagged");
   AST_SET_WINS: assert property (@(posedge core_clk) disable iff (!rstn) // [RQ25]
      ce && run && measure_done && flag_clr[`PMEV_F_MEAS] |=> flags[`PMEV_F_MEAS])
      else $error("measurement event lost to clear");
   AST_LOCKOUT: assert property (@(posedge core_clk) disable iff (!rstn) // [RQ12]
      ce && run && lock_s |=> !running)
      else $error("lockout did not stop the sequencer");
   AST_OFF_CLR: assert property (@(posedge core_clk) disable iff (!rstn) // [RQ12]
      ce && state_r == ST_OFF |=> flags == `PMEV_FLAGS_RST)
      else $error("flags survive lockout");
   AST_RST_FLAG: assert property (@(posedge core_clk) disable iff (!rstn) // [RQ13]
      ce && state_r == ST_LOAD |=> flags[`PMEV_F_RST] && reset_mask == $past(otp_reset_mask))
      else $error("reset flag or mask not loaded");
endmodule : pmev_top

// file: testbench/pmev_host.sv
// Host model: issues write-one-to-clear pulses on the flag clear vector.
// Assumes it is called at a falling edge of core_clk.
`timescale 1ns/1ps
module pmev_host (
   input  wire logic             core_clk, // Core clock
   output pmev_pkg::pmev_flags_t flag_clr  // Clear pulse to the block
);
   import pmev_pkg::*;
   initial flag_clr = '0;
   // One-cycle clear pulse; zero bits leave flags alone
   task automatic clear(input pmev_flags_t v);
      flag_clr = v;
      @(negedge core_clk);
      flag_clr = '0;
   endtask : clear
endmodule : pmev_host

// file: testbench/tb_pmic_event_and_power_ok_logic.sv
// Bench for the event, flag and power-ok block with a host clearing flags.
// Assumes pmev_top with a short debounce of 20 cycles; inputs change at falling edge.
`timescale 1ns/1ps
module tb_pmic_event_and_power_ok_logic;
   import pmev_pkg::*;
   logic core_clk = 0, rstn = 0, lko = 0, swr = 0, meas = 0, hw = 0, hsd = 0, ovp = 0, syn = 0, cde = 0;
   logic cen = 1, otm = 0, opm = 1, rmw = 0, rmd = 0;
   logic ga = 0, gb = 0, pol = 0, od = 0, hws = 0, ps, pm, rm, ga_o, gb_o, po, poe, irq, running;
   pmev_rail_t en = 0, il = 0, sl = 0, uv = '1, ov = '1, sel = 0, win = 0, gfm = '1, ocs, gs, re;
   pmev_flags_t flags, fclr;
   logic hws_o, hsd_o, ovp_o, syn_o;
   int bad_count = 0, checks = 0;
   always #4 core_clk = ~core_clk;
   pmev_host u_host (.core_clk(core_clk), .flag_clr(fclr));
   pmev_top #(.SHORT_CYC(20)) u_dut (.core_clk(core_clk), .rstn(rstn), .ce(cen),
      .supply_undervolt_lockout(lko), .sw_reset_req(swr), .otp_reset_mask(otm), .otp_power_ok_mode(opm),
      .reset_mask_wr(rmw), .reset_mask_wdata(rmd), .rail_en_req(en), .out_a_req(ga), .out_b_req(gb),
      .ilim_raw(il), .short_low_raw(sl), .above_uv_raw(uv), .below_ov_raw(ov), .hot_warning_raw(hw),
      .hot_shutdown_raw(hsd), .supply_overvolt_raw(ovp), .sync_clk_present_raw(syn), .clk_det_en(cde),
      .measure_done(meas), .flag_clr(fclr), .event_mask(19'h3ffff), .good_rise_mask(4'hf),
      .good_fall_mask(gfm), .monitor_select(sel), .hot_warning_monitor_select(hws), .rail_check_window(win),
      .power_ok_polarity(pol), .power_ok_drain_type(od), .flags(flags), .overcurrent_status(ocs),
      .good_status(gs), .hot_warning_status(hws_o), .hot_shutdown_status(hsd_o), .supply_overvolt_status(ovp_o),
      .sync_clk_status(syn_o), .power_ok_status(ps), .power_ok_mode(pm), .reset_mask(rm), .rail_enable(re),
      .general_output_a(ga_o), .general_output_b(gb_o), .power_ok_output_o(po), .power_ok_output_oe(poe),
      .irq_line_low(irq), .running(running));
   // Step on falling edges
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask : tick
   // Compare and count
   task automatic chk(input string nm, input logic [22:0] seen, input logic [22:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Bounded wait on a flag bit, or on running for index 19
   task automatic wait_on(input int i);
      int n;
      for (n = 0; n < 99 && (i < 19 ? flags[i] : running) !== 1'b1; n++) tick(1);
      if (n == 99) begin
         bad_count++;
         $display("ERROR wait_%0d expected 1 seen 0", i);
         wrap_up();
      end
   endtask : wait_on
   // Verdict and end of run
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : wrap_up
   // Main sequence
   initial begin
      tick(16);
      rstn = 1;
      wait_on(19);
      wait_on(18);
      tick(2);
      chk("irq_reset", {irq, pm}, 2'h1);
      u_host.clear(19'h0);
      tick(2);
      chk("zero_write", flags[18], 1);
      u_host.clear(19'h40000);
      tick(3);
      chk("irq_free", irq, 1);
      meas = 1;
      tick(1);
      meas = 0;
      tick(1);
      chk("meas", flags[17], 1);
      meas = 1;
      u_host.clear(19'h20000);
      meas = 0;
      tick(1);
      chk("meas_race", flags[17], 1);
      u_host.clear(19'h20000);
      chk("meas_clr", flags[17], 0);
      cen = 0;
      meas = 1;
      tick(2);
      meas = 0;
      cen = 1;
      chk("ce_hold", flags[17], 0);
      cde = 1;
      wait_on(16);
      chk("clk_det", {syn_o, flags[16]}, 2'h1);
      $display("test flags done");
      en = 4'h1;
      il = 4'h1;
      wait_on(0);
      chk("oc_stat", ocs, 4'h1);
      u_host.clear(19'h1);
      tick(2);
      chk("oc_hold", flags[0], 1);
      il = 0;
      tick(8);
      u_host.clear(19'h1);
      chk("oc_clr", flags[0], 0);
      sel = 4'h1;
      tick(8);
      chk("pok_on", {ps, po, poe}, 3'h7);
      pol = 1;
      tick(3);
      chk("pok_pol", {ps, po}, 2'h2);
      od = 1;
      tick(2);
      chk("pok_od", {po, poe}, 2'h1);
      hws = 1;
      hw = 1;
      wait_on(12);
      chk("warn", {hws_o, flags[12], ps, flags[15]}, 4'hd);
      u_host.clear(19'h1000);
      chk("warn_hold", flags[12], 1);
      hw = 0;
      tick(6);
      u_host.clear(19'h9000);
      gfm = 4'he;
      uv = 4'he;
      wait_on(15);
      chk("pok_fall", {ps, flags[8], gs}, 6'h1e);
      en = 0;
      tick(8);
      chk("pok_off_rail", ps, 1);
      $display("test power ok done");
      en = 4'h6;
      sl = 4'h6;
      wait_on(5);
      chk("short", {flags[6], re}, 5'h10);
      sl = 0;
      en = 4'h1;
      ga = 1;
      gb = 1;
      hsd = 1;
      ovp = 1;
      wait_on(13);
      chk("shutdown", {hsd_o, ovp_o, flags[14], ga_o, gb_o, re, ps}, 10'h380);
      rmw = 1;
      rmd = 1;
      opm = 0;
      tick(1);
      rmw = 0;
      chk("rm_wr", rm, 1);
      hsd = 0;
      ovp = 0;
      swr = 1;
      tick(1);
      swr = 0;
      tick(3);
      wait_on(18);
      chk("sw_reset", {flags[14:13], flags[5], rm, pm}, 5'h0);
      lko = 1;
      tick(10);
      chk("lockout", {flags, re}, 23'h0);
      $display("test protection done");
      wrap_up();
   end
endmodule : tb_pmic_event_and_power_ok_logic
